/* File: sfpe_flash_seq.sv */
`timescale 1ns/1ps
`default_nettype none
// What this block does
// R1: quad program 32h, address, data, needs quad enable
// R2: host sets write enable latch first
// R3: over 256 bytes keeps last 256 only; code does so up to 512 bytes, later bytes all land on the last page index
// R4: short program touches addressed bytes only
// R5: program needs chip select on byte boundary
// R6: program cycle tpp, busy high throughout
// R7: write enable latch cleared during each cycle
// R8: protected page program not executed
// R9: sector erase 20h, any address selects sector
// R10: sector erase ends right after address
// R11: sector erase runs t_se with busy
// R12: protected sector erase not executed
// R13: 32k block erase 52h selects block
// R14: 64k block erase d8h selects block
// R15: block erase exact end, t_be busy
// R16: protected block erase skipped, nothing changes
// R17: chip erase 60h/c7h, exactly eight bits
// R18: chip erase runs t_ce with busy
// R19: chip erase only when nothing protected
// R20: power-down b9h, entered t_dp after deselect
// R21: in power-down only abh, 66h/99h act
// R22: power-down rejected while cycle runs
// R23: standby after reset and idle deselect
// R24: page data wraps within same page
// R25: program/erase ignored without write enable
module sfpe_flash_seq
    import sfpe_pkg::*;
#(
    parameter int TPP_CYC = T_PP_CYC,
    parameter int TSE_CYC = T_SE_CYC,
    parameter int TBE_CYC = T_BE_CYC,
    parameter int TCE_CYC = T_CE_CYC
) (
    input  wire logic        core_clk,
    input  wire logic        arst_n,
    input  wire logic        spi_clk,
    input  wire logic        cs_n,
    input  wire logic [3:0]  io_in,
    input  wire logic        quad_lane_enable,
    input  wire logic        protect_bit4,
    input  wire logic        protect_bit3,
    input  wire logic        protect_bit2,
    input  wire logic        protect_bit1,
    input  wire logic        protect_bit0,
    input  wire logic        protect_complement,
    output logic             busy_flag,
    output logic             write_enable_latch,
    output logic             deep_powerdown,
    output logic             array_we,
    output logic [23:0]      array_addr,
    output logic [7:0]       array_wdata,
    output logic             erase_pulse,
    output logic [2:0]       erase_kind,
    output logic [23:0]      erase_addr
);
    // refuse counts the timer or the page copy cannot serve
    if (TPP_CYC < PAGE_BYTES || TSE_CYC < 2 || TBE_CYC < 2
        || TCE_CYC < 2) begin : g_bad_cyc
        $error("cycle counts too small for the sequencer");
    end

    // ----------------------------------------------------------------
    // reset release
    // ----------------------------------------------------------------
    logic rst_s1_reg, rst_n_reg;
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_s1_reg <= 1'b0;
            rst_n_reg  <= 1'b0;
        end else begin
            rst_s1_reg <= 1'b1;
            rst_n_reg  <= rst_s1_reg;
        end
    end

    // ----------------------------------------------------------------
    // link side: shift in on spi_clk rising edge
    // ----------------------------------------------------------------
    logic [5:0]  bitcnt_reg;      // bits taken, saturating
    logic [7:0]  opc_reg;
    logic [23:0] addr_reg;
    logic [7:0]  sh_reg;
    logic [2:0]  dbit_reg;        // data bit position within byte
    logic [8:0]  nbytes_reg;      // data bytes seen, saturating
    logic [7:0]  page_buf [PAGE_BYTES];
    logic [PAGE_BYTES-1:0] pmask_reg;
    logic        dtgl_reg;        // toggles on first link clock of each frame
    logic [5:0]  flen_reg;        // frame length kept past deselect
    logic [2:0]  fdbit_reg;       // nibble phase kept past deselect
    logic [7:0]  nxt_sh;
    logic        quad_now;
    always_comb begin
        quad_now = (opc_reg == OP_QUAD_PROG) && bitcnt_reg >= 6'd32;
        nxt_sh   = quad_now ? {sh_reg[3:0], io_in} : {sh_reg[6:0], io_in[0]};
    end

    // frame clears on cs_n high (async clear, frame ends with cs)
    always_ff @(posedge spi_clk or posedge cs_n) begin
        if (cs_n) begin
            bitcnt_reg <= 6'd0;
            dbit_reg   <= 3'd0;
            nbytes_reg <= 9'd0;
        end else begin
            if (bitcnt_reg != 6'h3f)
                bitcnt_reg <= bitcnt_reg + 6'd1;
            if (quad_now) begin
                dbit_reg <= dbit_reg + 3'd4;
                if (dbit_reg == 3'd4 && nbytes_reg != 9'h1ff)
                    nbytes_reg <= nbytes_reg + 9'd1;
            end
        end
    end

    // opcode, address and data capture
    always_ff @(posedge spi_clk) begin
        if (!cs_n) begin
            sh_reg <= nxt_sh;
            if (bitcnt_reg == 6'd7)
                opc_reg <= nxt_sh;
            else if (bitcnt_reg >= 6'd8 && bitcnt_reg < 6'd32)
                addr_reg <= {addr_reg[22:0], io_in[0]};
        end
    end

    // copies that survive the deselect clear, read by the core side
    always_ff @(posedge spi_clk) begin
        if (!cs_n && bitcnt_reg != 6'h3f)
            flen_reg <= bitcnt_reg + 6'd1;
        if (!cs_n)
            fdbit_reg <= quad_now ? dbit_reg + 3'd4 : 3'd0;
    end

    // page buffer; byte index wraps inside the page [R24] [R3]
    logic [7:0] wr_idx;
    always_comb wr_idx = addr_reg[7:0] + nbytes_reg[7:0];
    always_ff @(posedge spi_clk) begin
        if (!cs_n && quad_now && dbit_reg == 3'd4)
            page_buf[wr_idx] <= nxt_sh; // later bytes overwrite earlier [R3]
    end
    always_ff @(posedge spi_clk or negedge arst_n) begin
        if (!arst_n) begin
            pmask_reg <= '0;
            dtgl_reg  <= 1'b0;
        end else if (!cs_n && bitcnt_reg == 6'd31 && quad_now == 1'b0) begin
            pmask_reg <= '0;  // new frame: forget old mask [R4]
        end else if (!cs_n && quad_now && dbit_reg == 3'd4) begin
            pmask_reg[wr_idx] <= 1'b1;
        end else if (!cs_n && bitcnt_reg == 6'd0) begin
            dtgl_reg <= !dtgl_reg;    // first clock of a frame
        end
    end

    // ----------------------------------------------------------------
    // crossing: cs_n level into core domain; frame fields stable then
    // ----------------------------------------------------------------
    logic cs_s1_reg, cs_s2_reg, cs_s3_reg;
    always_ff @(posedge core_clk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            cs_s1_reg <= 1'b1;
            cs_s2_reg <= 1'b1;
            cs_s3_reg <= 1'b1;
        end else begin
            cs_s1_reg <= cs_n;
            cs_s2_reg <= cs_s1_reg;
            cs_s3_reg <= cs_s2_reg;
        end
    end
    logic frame_end, cs_rise, dseen_reg;
    always_comb cs_rise = cs_s2_reg && !cs_s3_reg;
    // a deselect with no link clock in it carries no new frame
    always_comb frame_end = cs_rise && (dtgl_reg != dseen_reg);
    always_ff @(posedge core_clk or negedge rst_n_reg) begin
        if (!rst_n_reg)
            dseen_reg <= 1'b0;
        else if (cs_rise)
            dseen_reg <= dtgl_reg;
    end

    // ----------------------------------------------------------------
    // decode at frame end
    // ----------------------------------------------------------------
    logic [2:0] bp_lo;
    logic       any_prot, tgt_prot, chip_ok;
    logic       exact8, exact32, prog_ok;
    sfpe_op_t   dec_op;
    always_comb begin
        bp_lo    = {protect_bit2, protect_bit1, protect_bit0};
        any_prot = protect_complement ? (bp_lo != 3'b111)
                                      : (bp_lo != 3'b000);
        // coarse map: any protection covers the target [R8] [R12] [R16]
        tgt_prot = any_prot || protect_bit3 || protect_bit4;
        chip_ok  = !any_prot;                                // [R19]
        exact8   = flen_reg == 6'd8;                         // [R17] [R20]
        exact32  = flen_reg == 6'd32;                        // [R10] [R15]
        prog_ok  = flen_reg >= 6'd34 && fdbit_reg == 3'd0;   // [R5]
        dec_op   = SFPE_OP_NONE;
        unique case (opc_reg)
            OP_QUAD_PROG:
                if (prog_ok && quad_lane_enable)              // [R1]
                    dec_op = SFPE_OP_PROG;
            OP_SECT_ERASE:  if (exact32) dec_op = SFPE_OP_SECT;  // [R9]
            OP_BLK32_ERASE: if (exact32) dec_op = SFPE_OP_BLK32; // [R13]
            OP_BLK64_ERASE: if (exact32) dec_op = SFPE_OP_BLK64; // [R14]
            OP_CHIP_ERASE0, OP_CHIP_ERASE1:
                if (exact8 && chip_ok) dec_op = SFPE_OP_CHIP;
            OP_DEEP_PD:    if (exact8) dec_op = SFPE_OP_DP;
            OP_RELEASE_PD, OP_RST_DEVICE:
                if (exact8) dec_op = SFPE_OP_WAKE;           // [R21]
            default: dec_op = SFPE_OP_NONE;
        endcase
        if ((dec_op == SFPE_OP_PROG || dec_op == SFPE_OP_SECT
             || dec_op == SFPE_OP_BLK32 || dec_op == SFPE_OP_BLK64)
            && tgt_prot)
            dec_op = SFPE_OP_NONE;
    end

    // write enable opcode seen (latch owned here, cleared by cycles)
    logic wen_cmd;
    always_comb wen_cmd = (opc_reg == OP_WRITE_EN) && exact8;

    // ----------------------------------------------------------------
    // sequencer
    // ----------------------------------------------------------------
    sfpe_state_t state_reg;
    sfpe_op_t    op_reg;
    logic [31:0] tmr_reg;
    logic [8:0]  pidx_reg;
    logic        rst_armed_reg;
    always_ff @(posedge core_clk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            state_reg     <= SFPE_IDLE;                      // [R23]
            op_reg        <= SFPE_OP_NONE;
            tmr_reg       <= '0;
            rst_armed_reg <= 1'b0;
        end else begin
            unique case (state_reg)
                SFPE_IDLE: if (frame_end) begin
                    if (dec_op == SFPE_OP_DP) begin
                        state_reg <= SFPE_PDENT;
                        tmr_reg   <= 32'(T_DP_CYC);          // [R20]
                    end else if (write_enable_latch          // [R25] [R2]
                                 && dec_op inside {SFPE_OP_PROG,
                                 SFPE_OP_SECT, SFPE_OP_BLK32,
                                 SFPE_OP_BLK64, SFPE_OP_CHIP}) begin
                        state_reg <= SFPE_BUSY;
                        op_reg    <= dec_op;
                        unique case (dec_op)
                            SFPE_OP_PROG:  tmr_reg <= 32'(TPP_CYC);  // [R6]
                            SFPE_OP_SECT:  tmr_reg <= 32'(TSE_CYC);  // [R11]
                            SFPE_OP_CHIP:  tmr_reg <= 32'(TCE_CYC);  // [R18]
                            default:       tmr_reg <= 32'(TBE_CYC);  // [R15]
                        endcase
                    end
                end
                // busy: power-down and all else rejected [R22]
                SFPE_BUSY: begin
                    tmr_reg <= tmr_reg - 32'd1;
                    if (tmr_reg == 32'd1) begin
                        state_reg <= SFPE_IDLE;
                        op_reg    <= SFPE_OP_NONE;
                    end
                end
                SFPE_PDENT: begin
                    tmr_reg <= tmr_reg - 32'd1;
                    if (tmr_reg <= 32'd1)
                        state_reg <= SFPE_PDOWN;
                end
                SFPE_PDOWN: if (frame_end) begin             // [R21]
                    rst_armed_reg <= opc_reg == OP_RST_ENABLE && exact8;
                    if (opc_reg == OP_RELEASE_PD && exact8)
                        state_reg <= SFPE_IDLE;
                    else if (opc_reg == OP_RST_DEVICE && exact8
                             && rst_armed_reg)
                        state_reg <= SFPE_IDLE;
                end
            endcase
        end
    end

    // write enable latch: set by command, cleared in last busy cycle [R7]
    always_ff @(posedge core_clk or negedge rst_n_reg) begin
        if (!rst_n_reg)
            write_enable_latch <= 1'b0;
        else if (state_reg == SFPE_BUSY && tmr_reg == 32'(WEL_CLR_CYC))
            write_enable_latch <= 1'b0;                      // [R7]
        else if (state_reg == SFPE_IDLE && frame_end && wen_cmd)
            write_enable_latch <= 1'b1;
    end

    // status outputs
    always_ff @(posedge core_clk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            busy_flag      <= 1'b0;
            deep_powerdown <= 1'b0;
        end else begin
            busy_flag      <= state_reg == SFPE_BUSY;        // [R6]
            deep_powerdown <= state_reg == SFPE_PDOWN;       // [R20]
        end
    end

    // ----------------------------------------------------------------
    // array writes: masked bytes only, during program cycle [R4]
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            pidx_reg    <= '0;
            array_we    <= 1'b0;
            array_addr  <= '0;
            array_wdata <= '0;
            erase_pulse <= 1'b0;
            erase_kind  <= '0;
            erase_addr  <= '0;
        end else begin
            array_we    <= 1'b0;
            erase_pulse <= 1'b0;
            if (state_reg == SFPE_IDLE && frame_end) begin
                pidx_reg   <= '0;
                erase_addr <= addr_reg;   // block picked by upper bits
                erase_kind <= 3'(dec_op);
            end else if (state_reg == SFPE_BUSY && op_reg == SFPE_OP_PROG
                         && !pidx_reg[8]) begin
                pidx_reg    <= pidx_reg + 9'd1;
                array_we    <= pmask_reg[pidx_reg[7:0]];     // [R4]
                array_addr  <= {erase_addr[23:8], pidx_reg[7:0]};
                array_wdata <= page_buf[pidx_reg[7:0]];
            end
            if (state_reg == SFPE_BUSY && tmr_reg == 32'd1
                && op_reg != SFPE_OP_PROG)
                erase_pulse <= 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    wel_clear_a: assert property ( // [R7]
        @(posedge core_clk) disable iff (!rst_n_reg)
        $fell(busy_flag) |-> !write_enable_latch)
        else $error("latch still set after cycle");
    dp_reject_a: assert property ( // [R22]
        @(posedge core_clk) disable iff (!rst_n_reg)
        state_reg == SFPE_BUSY |=> state_reg != SFPE_PDENT)
        else $error("power-down taken while busy");
    no_wel_a: assert property ( // [R25]
        @(posedge core_clk) disable iff (!rst_n_reg)
        state_reg == SFPE_IDLE && !write_enable_latch
        |=> state_reg != SFPE_BUSY)
        else $error("cycle without write enable");
    busy_follow_a: assert property ( // [R6]
        @(posedge core_clk) disable iff (!rst_n_reg)
        $rose(state_reg == SFPE_BUSY) |=> busy_flag [*2])
        else $error("busy flag not held");
    dp_entry_a: assert property ( // [R20]
        @(posedge core_clk) disable iff (!rst_n_reg)
        $rose(state_reg == SFPE_PDENT)
        |-> ##[1:30] state_reg == SFPE_PDOWN)
        else $error("power-down not entered in time");
    chip_prot_a: assert property ( // [R19]
        @(posedge core_clk) disable iff (!rst_n_reg)
        state_reg == SFPE_IDLE && any_prot |=> op_reg != SFPE_OP_CHIP)
        else $error("chip erase under protection");
    wel_idle_a: assert property ( // [R21]
        @(posedge core_clk) disable iff (!rst_n_reg)
        $rose(write_enable_latch) |-> state_reg == SFPE_IDLE)
        else $error("latch set outside idle");
endmodule // sfpe_flash_seq
`default_nettype wire

/* File: sfpe_flash_seq_test.sv */
`timescale 1ns/1ps
`default_nettype none
module sfpe_flash_seq_test;
    import sfpe_pkg::*;
    localparam int TPP = 300;
    localparam int TSE = 200;
    localparam int TBE = 20;
    localparam int TCE = 20;
    logic            core_clk;
    logic            arst_n;
    wire logic       spi_clk;
    wire logic       cs_n;
    wire logic [3:0] io_in;
    logic            qe;
    logic [4:0]      bp;
    logic            cmp;
    logic            busy_flag;
    logic            write_enable_latch;
    logic            deep_powerdown;
    logic            array_we;
    logic [23:0]     array_addr;
    logic [7:0]      array_wdata;
    logic            erase_pulse;
    logic [2:0]      erase_kind;
    logic [23:0]     erase_addr;
    int              n_errors = 0;
    int              n_tests = 0;
    int              n_erase = 0;
    int              ne;
    logic [2:0]      e_kind;
    logic [23:0]     e_addr;
    logic [23:0]     wa[$];
    logic [7:0]      wd[$];
    logic [7:0]      eops [5] = '{OP_SECT_ERASE, OP_BLK32_ERASE,
        OP_BLK64_ERASE, OP_CHIP_ERASE0, OP_CHIP_ERASE1};
    sfpe_op_t        ekind [5] = '{SFPE_OP_SECT, SFPE_OP_BLK32,
        SFPE_OP_BLK64, SFPE_OP_CHIP, SFPE_OP_CHIP};
    int              esh [5] = '{12, 15, 16, 24, 24};
    int              elen [5] = '{TSE, TBE, TBE, TCE, TCE};

    sfpe_host_model i_host (.spi_clk(spi_clk), .cs_n(cs_n), .io(io_in));

    sfpe_flash_seq #(.TPP_CYC(TPP), .TSE_CYC(TSE), .TBE_CYC(TBE),
                     .TCE_CYC(TCE)) i_dut (
        .core_clk(core_clk), .arst_n(arst_n), .spi_clk(spi_clk),
        .cs_n(cs_n), .io_in(io_in), .quad_lane_enable(qe),
        .protect_bit4(bp[4]), .protect_bit3(bp[3]), .protect_bit2(bp[2]),
        .protect_bit1(bp[1]), .protect_bit0(bp[0]),
        .protect_complement(cmp), .busy_flag(busy_flag),
        .write_enable_latch(write_enable_latch),
        .deep_powerdown(deep_powerdown), .array_we(array_we),
        .array_addr(array_addr), .array_wdata(array_wdata),
        .erase_pulse(erase_pulse), .erase_kind(erase_kind),
        .erase_addr(erase_addr));

    // ------------------------------------------------------------
    // clock, array and erase monitors
    // ------------------------------------------------------------
    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end

    // record array writes and erase completions
    always @(posedge core_clk) begin
        if (array_we === 1'b1) begin
            wa.push_back(array_addr);
            wd.push_back(array_wdata);
        end
        if (erase_pulse === 1'b1) begin
            n_erase++;
            e_kind = erase_kind;
            e_addr = erase_addr;
        end
    end

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic final_report();
        $display("checks %0d, errors %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED at %0t: got %0h expected %0h",
                     $time, got, exp);
        end
    endtask

    // one write to an address with the given data was made
    task automatic wr_check(input logic [23:0] a, input logic [7:0] d);
        logic found;
        found = 1'b0;
        foreach (wa[i]) if (wa[i] === a) begin
            found = 1'b1;
            check(wd[i], d);
        end
        check(found, 1);
    endtask

    // optional write enable, command frame, busy seen or not, length
    task automatic op(input logic [7:0] opc, input int ab,
                      input logic [23:0] a, input int nib, input int extra,
                      input logic we, input logic exp, input logic pd,
                      input int len);
        int   k;
        logic seen;
        seen = 1'b0;
        wa.delete();
        wd.delete();
        if (we) i_host.frame(OP_WRITE_EN, 0, 24'h0, 0, 8'h0, 0);
        i_host.frame(opc, ab, a, nib, 8'h10, extra);
        for (k = 0; k < 40 && !seen; k++) begin
            @(posedge core_clk);
            seen = (busy_flag === 1'b1);
        end
        check(seen, exp);
        if (pd) fork
            i_host.frame(OP_DEEP_PD, 0, 24'h0, 0, 8'h0, 0);
        join_none
        if (exp) begin
            k = 0;
            while (busy_flag !== 1'b0) begin
                @(posedge core_clk);
                k++;
                if (k > 3000) begin
                    n_errors++;
                    final_report();
                end
            end
            check(k >= len - 10 && k <= len + 2, 1);
            check(write_enable_latch, 0);
            repeat (5) @(posedge core_clk);
        end
    endtask

    task automatic wait_pd(input logic v);
        for (int k = 0; k < 100 && deep_powerdown !== v; k++)
            @(posedge core_clk);
        check(deep_powerdown, v);
    endtask

    task automatic set_cfg(input logic q, input logic [4:0] b, input logic c);
        @(posedge core_clk);
        #1 qe = q;
        bp = b;
        cmp = c;
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        arst_n = 1'b0;
        qe = 1'b1;
        bp = 5'h00;
        cmp = 1'b0;
        repeat (5) @(posedge core_clk);
        #1 arst_n = 1'b1;
        repeat (4) @(posedge core_clk);
        check({busy_flag, write_enable_latch, deep_powerdown}, 0);
        op(OP_QUAD_PROG, 24, 24'h0000fe, 6, 0, 1, 1, 0, TPP);
        check(wa.size(), 3);
        for (int i = 0; i < 3; i++)
            wr_check({16'h0, 8'(8'hfe + i)}, 8'(8'h10 + i));
        op(OP_QUAD_PROG, 24, 24'h001200, 516, 0, 1, 1, 0, TPP);
        check(wa.size(), 256);
        wr_check(24'h001200, 8'h11);
        wr_check(24'h0012ff, 8'h0f);
        op(OP_QUAD_PROG, 24, 24'h000000, 4, 0, 0, 0, 0, 0);
        op(OP_QUAD_PROG, 24, 24'h000000, 3, 0, 1, 0, 0, 0);
        set_cfg(1'b0, 5'h00, 1'b0);
        op(OP_QUAD_PROG, 24, 24'h000000, 2, 0, 1, 0, 0, 0);
        set_cfg(1'b1, 5'h00, 1'b0);
        for (int i = 0; i < 5; i++) begin
            ne = n_erase;
            op(eops[i], i < 3 ? 24 : 0, 24'h5ab7c3, 0, 0, 1, 1, 0,
               elen[i]);
            check(n_erase - ne, 1);
            check(e_kind, ekind[i]);
            check(e_addr >> esh[i], 24'h5ab7c3 >> esh[i]);
        end
        ne = n_erase;
        op(OP_SECT_ERASE, 24, 24'h0, 0, 1, 1, 0, 0, 0);
        op(OP_CHIP_ERASE0, 0, 24'h0, 0, 1, 1, 0, 0, 0);
        set_cfg(1'b1, 5'h01, 1'b0);
        op(OP_QUAD_PROG, 24, 24'h0, 2, 0, 1, 0, 0, 0);
        op(OP_SECT_ERASE, 24, 24'h0, 0, 0, 1, 0, 0, 0);
        op(OP_BLK64_ERASE, 24, 24'h0, 0, 0, 1, 0, 0, 0);
        set_cfg(1'b1, 5'h07, 1'b0);
        op(OP_CHIP_ERASE1, 0, 24'h0, 0, 0, 1, 0, 0, 0);
        check(n_erase - ne, 0);
        set_cfg(1'b1, 5'h07, 1'b1);
        op(OP_CHIP_ERASE1, 0, 24'h0, 0, 0, 1, 1, 0, TCE);
        check(n_erase - ne, 1);
        set_cfg(1'b1, 5'h00, 1'b0);
        op(OP_SECT_ERASE, 24, 24'h0, 0, 0, 1, 1, 1, TSE);
        repeat (40) @(posedge core_clk);
        check(deep_powerdown, 0);
        i_host.frame(OP_DEEP_PD, 0, 24'h0, 0, 8'h0, 0);
        check(deep_powerdown, 0);
        wait_pd(1'b1);
        op(OP_SECT_ERASE, 24, 24'h0, 0, 0, 1, 0, 0, 0);
        i_host.frame(OP_RELEASE_PD, 0, 24'h0, 0, 8'h0, 0);
        wait_pd(1'b0);
        i_host.frame(OP_DEEP_PD, 0, 24'h0, 0, 8'h0, 0);
        wait_pd(1'b1);
        i_host.frame(OP_RST_ENABLE, 0, 24'h0, 0, 8'h0, 0);
        i_host.frame(OP_RST_DEVICE, 0, 24'h0, 0, 8'h0, 0);
        wait_pd(1'b0);
        final_report();
    end
endmodule // sfpe_flash_seq_test
`default_nettype wire

/* File: sfpe_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module sfpe_host_model (
    output logic       spi_clk,
    output logic       cs_n,
    output logic [3:0] io
);
    // ------------------------------------------------------------
    // host side of the serial link, clock stands still between frames
    // ------------------------------------------------------------
    initial begin
        spi_clk = 1'b0;
        cs_n    = 1'b1;
        io      = 4'h0;
    end

    // one link clock, 32 ns period, data set while clock low
    task automatic bit_out(input logic [3:0] v);
        io = v;
        #16 spi_clk = 1'b1;
        #16 spi_clk = 1'b0;
    endtask

    // opcode, address msb first on lane 0, quad data high nibble first
    task automatic frame(input logic [7:0] op, input int ab,
                         input logic [23:0] a, input int nib,
                         input logic [7:0] d0, input int extra);
        logic [7:0] b;
        cs_n = 1'b0;
        #16;
        for (int i = 7; i >= 0; i--) bit_out({3'h5, op[i]});
        for (int i = 0; i < ab; i++) bit_out({3'h5, a[23-i]});
        for (int j = 0; j < nib; j++) begin
            b = 8'(int'(d0) + j / 2 + j / 512);
            bit_out(j % 2 ? b[3:0] : b[7:4]);
        end
        for (int i = 0; i < extra; i++) bit_out(4'h1);
        #16 cs_n = 1'b1;
        io = ~io; // released lines do not keep the last value
        #40;
    endtask
endmodule // sfpe_host_model
`default_nettype wire

/* File: sfpe_pkg.sv */
package sfpe_pkg;
    // ----------------------------------------------------------------
    // opcodes
    // ----------------------------------------------------------------
    localparam logic [7:0] OP_QUAD_PROG   = 8'h32;
    localparam logic [7:0] OP_SECT_ERASE  = 8'h20;
    localparam logic [7:0] OP_BLK32_ERASE = 8'h52;
    localparam logic [7:0] OP_BLK64_ERASE = 8'hd8;
    localparam logic [7:0] OP_CHIP_ERASE0 = 8'h60;
    localparam logic [7:0] OP_CHIP_ERASE1 = 8'hc7;
    localparam logic [7:0] OP_DEEP_PD     = 8'hb9;
    localparam logic [7:0] OP_RELEASE_PD  = 8'hab;
    localparam logic [7:0] OP_RST_ENABLE  = 8'h66;
    localparam logic [7:0] OP_RST_DEVICE  = 8'h99;
    localparam logic [7:0] OP_WRITE_EN    = 8'h06;
    // ----------------------------------------------------------------
    // geometry
    // ----------------------------------------------------------------
    localparam int PAGE_BYTES   = 256;
    localparam int ADDR_BITS    = 24;
    localparam int CMD_ADDR_CNT = 32;
    // ----------------------------------------------------------------
    // timing (ns) and core-clock counts
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 5;
    localparam int T_PP_NS       = 2400;
    localparam int T_SE_NS       = 20000;
    localparam int T_BE_NS       = 100000;
    localparam int T_CE_NS       = 1000000;
    localparam int T_DP_NS       = 100;
    localparam int T_PP_CYC = (T_PP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int T_SE_CYC = (T_SE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int T_BE_CYC = (T_BE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int T_CE_CYC = (T_CE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int T_DP_CYC = (T_DP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WEL_CLR_CYC = 1;
    // ----------------------------------------------------------------
    // sequencer states and operation kinds
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        SFPE_IDLE  = 2'b00,
        SFPE_BUSY  = 2'b01,
        SFPE_PDENT = 2'b11,
        SFPE_PDOWN = 2'b10
    } sfpe_state_t;
    typedef enum logic [2:0] {
        SFPE_OP_NONE, SFPE_OP_PROG, SFPE_OP_SECT, SFPE_OP_BLK32,
        SFPE_OP_BLK64, SFPE_OP_CHIP, SFPE_OP_DP, SFPE_OP_WAKE
    } sfpe_op_t;
endpackage
